// ===== rtl/fp_exception_detect_priority.sv
// Notes on behaviour
// - Unsupported operand types raise unsupported-type exception.
// - Register or memory source classes trap pre-instruction.
// - Register-to-memory class traps post-instruction immediately.
// - Frame zero or three, vector 55.
// - Denormal result gives nonmaskable underflow instead.
// - Odd extended operands saved unmodified into slots.
// - Packed source split: upper 32, lower 64.
// - Fixed eight-level arithmetic priority; hardware makes seven.
// - Hardware never sets decimal inexact; software latch.
// - Maskable taken only on executed bit plus enable.
// - Software status writes never cause exceptions.
// - Enabling later ignores earlier recorded conditions.
// - Cleared enable bit disables its class.
// - Nonmaskable conditions trap regardless of enables.
// - Only highest-priority enabled exception is reported.
// - Enable bit 15 highest, bit 8 lowest.
// - Listed exception combinations may occur together.
// - Handler vector follows the exception class.
// - Entry copies status, sets supervisor, clears trace.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module fp_exception_detect_priority #(
    parameter int ADDR_W = 6
) (
    input wire logic aclk, // Processor clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [ADDR_W-1:0] awaddr, // Write address.
    input wire logic [2:0] awprot, // Unused protection.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [ADDR_W-1:0] araddr, // Read address.
    input wire logic [2:0] arprot, // Unused protection.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire fp_exc_pkg::insn_t insn, // Instruction operand check.
    input wire fp_exc_pkg::result_t result, // Arithmetic result flags.
    input wire logic [15:0] sr_in, // Current status register.
    output fp_exc_pkg::take_t take, // Exception taken, one pulse.
    output logic [15:0] sr_saved, // Internal copy of status.
    output logic [15:0] sr_out, // Status after entry.
    output logic irq // Level interrupt.
);
    import fp_exc_pkg::*;

    if (ADDR_W < 6 || ADDR_W > 32) begin : addr_w_check
        $error("ADDR_W must lie between 6 and 32.");
    end

    typedef struct packed {
        logic [31:0] fp_status_reg;
        logic [31:0] fp_control_reg;
        logic [1:0] int_stat;
        logic [1:0] int_mask;
        logic [79:0] exc_slot;
        logic [79:0] dst_slot;
        take_t take;
        logic [15:0] sr_saved;
        logic [15:0] sr_out;
        logic irq;
        logic [5:0] awaddr;
        logic aw_have;
        logic aw_bad;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ************************************************************
    // Event decode
    // ************************************************************
    logic bad_type_c;
    logic class_pre_c;
    logic class_post_c;
    logic unsup_c;
    logic arith_c;
    logic [7:0] hw_exc_c;
    logic [7:0] trig_c;
    logic wr_go_c;
    logic [ADDR_W-1:0] aw_hi_c;
    logic [ADDR_W-1:0] ar_hi_c;
    logic aw_bad_c;
    logic ar_bad_c;

    assign bad_type_c = insn.src_denorm | insn.src_unnorm | insn.dst_denorm
                      | insn.dst_unnorm | insn.src_packed | insn.dst_packed;
    assign class_pre_c = insn.opclass == OPC_REG_REG
                       || insn.opclass == OPC_MEM_REG;
    assign class_post_c = insn.opclass == OPC_REG_MEM;
    assign unsup_c = insn.valid && bad_type_c
                   && (class_pre_c || class_post_c);
    // The decimal inexact bit is masked off here; only software sets it.
    assign hw_exc_c = result.valid
                    ? ((result.exc & HW_BITS)
                      | (8'(result.result_denorm) << B_UNDERFLOW_EXC))
                    : 8'h00;
    // Only bits raised by execution meet the enables, so old status bits
    // and software writes can never start an exception.
    assign trig_c = (hw_exc_c & s_r.fp_control_reg[EXC_MSB:EXC_LSB])
                  | (result.valid ? (result.nonmask & NONMASK_BITS)
                                  : 8'h00)
                  | (8'(result.valid & result.result_denorm)
                    << B_UNDERFLOW_EXC);
    assign arith_c = result.valid && (trig_c != 8'h00) && !unsup_c;
    assign wr_go_c = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    // Offsets past the map or off a word boundary are refused.
    assign aw_hi_c = awaddr >> 6;
    assign ar_hi_c = araddr >> 6;
    assign aw_bad_c = awaddr[1:0] != 2'h0 || aw_hi_c != '0;
    assign ar_bad_c = araddr[1:0] != 2'h0 || ar_hi_c != '0;

    function automatic logic [7:0] pick_vector(input logic [7:0] t);
        logic [7:0] v;
        v = VEC_INEX;
        if (t[B_UNORD]) begin
            v = VEC_UNORD;
        end else if (t[B_SIGNALING_NAN_EXC]) begin
            v = VEC_SIGNALING_NAN_EXC;
        end else if (t[B_OPERAND_ERROR_EXC]) begin
            v = VEC_OPERAND_ERROR_EXC;
        end else if (t[B_OVERFLOW_EXC]) begin
            v = VEC_OVERFLOW_EXC;
        end else if (t[B_UNDERFLOW_EXC]) begin
            v = VEC_UNDERFLOW_EXC;
        end else if (t[B_DZ]) begin
            v = VEC_DZ;
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [5:0] ra;
        logic [5:0] wa;
        ra = araddr[5:0];
        wa = s_r.awaddr;
        s_nxt = s_r;
        s_nxt.take.valid = 1'b0;
        if (awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.awaddr = awaddr[5:0];
            s_nxt.aw_bad = aw_bad_c;
        end
        if (wvalid && s_r.wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wdata = wdata;
            s_nxt.wstrb = wstrb;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go_c) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (s_r.aw_bad) begin
                s_nxt.bresp = RESP_SLVERR;
            end else if (wa == OFS_FP_STATUS) begin
                s_nxt.fp_status_reg = merge(s_r.fp_status_reg, s_r.wdata, s_r.wstrb);
            end else if (wa == OFS_FP_CONTROL) begin
                s_nxt.fp_control_reg = merge(s_r.fp_control_reg, s_r.wdata, s_r.wstrb);
            end else if (wa == OFS_INT_MASK) begin
                if (s_r.wstrb[0]) begin
                    s_nxt.int_mask = s_r.wdata[1:0];
                end
            end else if (wa != OFS_INT_STATUS) begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = RST_WORD;
            if (ar_bad_c) begin
                s_nxt.rresp = RESP_SLVERR;
            end else if (ra == OFS_FP_STATUS) begin
                s_nxt.rdata = s_r.fp_status_reg;
            end else if (ra == OFS_FP_CONTROL) begin
                s_nxt.rdata = s_r.fp_control_reg;
            end else if (ra == OFS_INT_STATUS) begin
                s_nxt.rdata = {30'h0, s_r.int_stat};
                s_nxt.int_stat = 2'h0;
            end else if (ra == OFS_INT_MASK) begin
                s_nxt.rdata = {30'h0, s_r.int_mask};
            end else if (ra == OFS_EXC_SLOT0) begin
                s_nxt.rdata = s_r.exc_slot[31:0];
            end else if (ra == OFS_EXC_SLOT1) begin
                s_nxt.rdata = s_r.exc_slot[63:32];
            end else if (ra == OFS_EXC_SLOT2) begin
                s_nxt.rdata = {16'h0, s_r.exc_slot[79:64]};
            end else if (ra == OFS_DST_SLOT0) begin
                s_nxt.rdata = s_r.dst_slot[31:0];
            end else if (ra == OFS_DST_SLOT1) begin
                s_nxt.rdata = s_r.dst_slot[63:32];
            end else if (ra == OFS_DST_SLOT2) begin
                s_nxt.rdata = {16'h0, s_r.dst_slot[79:64]};
            end else begin
                s_nxt.rresp = RESP_SLVERR;
            end
        end
        // Hardware sets come after software writes and read clears.
        s_nxt.fp_status_reg[EXC_MSB:EXC_LSB] = s_nxt.fp_status_reg[EXC_MSB:EXC_LSB]
                                    | hw_exc_c;
        if (unsup_c) begin
            s_nxt.take.valid = 1'b1;
            s_nxt.take.vector = VEC_UNSUP;
            s_nxt.take.post = class_post_c;
            s_nxt.take.frame_fmt = class_post_c ? FMT_POST : FMT_PRE;
            s_nxt.int_stat[IB_UNSUP] = 1'b1;
            if (insn.src_packed) begin
                s_nxt.dst_slot = {48'h0, insn.packed_src[95:64]};
                s_nxt.exc_slot = {16'h0, insn.packed_src[63:0]};
            end else begin
                s_nxt.exc_slot = insn.src_op;
                s_nxt.dst_slot = insn.dst_op;
            end
        end else if (arith_c) begin
            s_nxt.take.valid = 1'b1;
            s_nxt.take.vector = pick_vector(trig_c);
            s_nxt.take.post = 1'b0;
            s_nxt.take.frame_fmt = FMT_PRE;
        end
        if (unsup_c || arith_c) begin
            s_nxt.int_stat[IB_TAKEN] = 1'b1;
            s_nxt.sr_saved = sr_in;
            s_nxt.sr_out = sr_in;
            s_nxt.sr_out[SR_S] = 1'b1;
            s_nxt.sr_out[SR_T1] = 1'b0;
            s_nxt.sr_out[SR_T0] = 1'b0;
        end
        s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
        s_nxt.awready = !s_nxt.aw_have;
        s_nxt.wready = !s_nxt.w_have;
        s_nxt.arready = !s_nxt.rvalid;
        if (!aresetn) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign take = s_r.take;
    assign sr_saved = s_r.sr_saved;
    assign sr_out = s_r.sr_out;
    assign irq = s_r.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    unsup_vector_a: assert property (unsup_c |=>
        take.valid && take.vector == VEC_UNSUP)
        else $error("Unsupported type not trapped on vector 55.");
    pre_frame_a: assert property (unsup_c && class_pre_c |=>
        !take.post && take.frame_fmt == FMT_PRE)
        else $error("Pre-instruction frame wrong.");
    post_frame_a: assert property (unsup_c && class_post_c |=>
        take.post && take.frame_fmt == FMT_POST)
        else $error("Post-instruction frame wrong.");
    denorm_underflow_exc_a: assert property (result.valid
        && result.result_denorm && !unsup_c |=> take.valid
        && take.vector != VEC_UNSUP && s_r.fp_status_reg[EXC_LSB + B_UNDERFLOW_EXC])
        else $error("Denormal result did not raise underflow.");
    packed_split_a: assert property (unsup_c && insn.src_packed
        |=> s_r.dst_slot[31:0] == $past(insn.packed_src[95:64])
        && s_r.exc_slot[63:0] == $past(insn.packed_src[63:0]))
        else $error("Packed operand split wrong.");
    slot_copy_a: assert property (unsup_c && !insn.src_packed
        |=> s_r.exc_slot == $past(insn.src_op))
        else $error("Operand slot modified.");
    inexd_hw_a: assert property (
        $rose(s_r.fp_status_reg[EXC_LSB + B_INEXD]) |-> $past(wr_go_c))
        else $error("Hardware set decimal inexact.");
    sw_quiet_a: assert property (!result.valid && !insn.valid
        |=> !take.valid)
        else $error("Exception without an execution event.");
    masked_a: assert property (result.valid && !unsup_c
        && (result.exc & HW_BITS & s_r.fp_control_reg[EXC_MSB:EXC_LSB]) == 8'h00
        && (result.nonmask & NONMASK_BITS) == 8'h00
        && !result.result_denorm |=> !take.valid)
        else $error("Disabled class was taken.");
    nonmask_a: assert property (result.valid && !unsup_c
        && (result.nonmask & NONMASK_BITS) != 8'h00 |=> take.valid)
        else $error("Nonmaskable condition not taken.");
    unord_first_a: assert property (arith_c && trig_c[B_UNORD]
        |=> take.vector == VEC_UNORD)
        else $error("Highest class not chosen.");
    entry_sr_a: assert property (take.valid |-> sr_out[SR_S]
        && !sr_out[SR_T1] && !sr_out[SR_T0]
        && sr_saved == $past(sr_in))
        else $error("Entry status wrong.");

    unsup_post_c: cover property (unsup_c && class_post_c ##1 take.valid);
    multi_exc_c: cover property (arith_c && trig_c[B_OVERFLOW_EXC]
        && trig_c[B_INEXR]);
    irq_read_c: cover property (irq ##[1:8] arvalid && arready);

endmodule

`default_nettype wire

// ===== rtl/fp_exc_pkg.sv
package fp_exc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [5:0] OFS_FP_STATUS = 6'h00;
    localparam logic [5:0] OFS_FP_CONTROL = 6'h04;
    localparam logic [5:0] OFS_INT_STATUS = 6'h08;
    localparam logic [5:0] OFS_INT_MASK = 6'h0C;
    localparam logic [5:0] OFS_EXC_SLOT0 = 6'h10;
    localparam logic [5:0] OFS_EXC_SLOT1 = 6'h14;
    localparam logic [5:0] OFS_EXC_SLOT2 = 6'h18;
    localparam logic [5:0] OFS_DST_SLOT0 = 6'h1C;
    localparam logic [5:0] OFS_DST_SLOT1 = 6'h20;
    localparam logic [5:0] OFS_DST_SLOT2 = 6'h24;

    // ************************************************************
    // Field layouts
    // ************************************************************
    localparam int EXC_LSB = 8;
    localparam int EXC_MSB = 15;
    localparam int B_UNORD = 7;
    localparam int B_SIGNALING_NAN_EXC = 6;
    localparam int B_OPERAND_ERROR_EXC = 5;
    localparam int B_OVERFLOW_EXC = 4;
    localparam int B_UNDERFLOW_EXC = 3;
    localparam int B_DZ = 2;
    localparam int B_INEXR = 1;
    localparam int B_INEXD = 0;
    localparam logic [7:0] NONMASK_BITS = 8'h78;
    localparam logic [7:0] HW_BITS = 8'hFE;
    localparam int SR_T1 = 15;
    localparam int SR_T0 = 14;
    localparam int SR_S = 13;
    localparam int IB_TAKEN = 0;
    localparam int IB_UNSUP = 1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Classes, frames and vectors
    // ************************************************************
    localparam logic [2:0] OPC_REG_REG = 3'h0;
    localparam logic [2:0] OPC_MEM_REG = 3'h2;
    localparam logic [2:0] OPC_REG_MEM = 3'h3;
    localparam logic [3:0] FMT_PRE = 4'h0;
    localparam logic [3:0] FMT_POST = 4'h3;
    localparam logic [7:0] VEC_UNORD = 8'h30;
    localparam logic [7:0] VEC_INEX = 8'h31;
    localparam logic [7:0] VEC_DZ = 8'h32;
    localparam logic [7:0] VEC_UNDERFLOW_EXC = 8'h33;
    localparam logic [7:0] VEC_OPERAND_ERROR_EXC = 8'h34;
    localparam logic [7:0] VEC_OVERFLOW_EXC = 8'h35;
    localparam logic [7:0] VEC_SIGNALING_NAN_EXC = 8'h36;
    localparam logic [7:0] VEC_UNSUP = 8'h37;

    typedef struct packed {
        logic valid;
        logic [2:0] opclass;
        logic src_denorm;
        logic src_unnorm;
        logic dst_denorm;
        logic dst_unnorm;
        logic src_packed;
        logic dst_packed;
        logic [79:0] src_op;
        logic [79:0] dst_op;
        logic [95:0] packed_src;
    } insn_t;

    typedef struct packed {
        logic valid;
        logic [7:0] exc;
        logic [7:0] nonmask;
        logic result_denorm;
    } result_t;

    typedef struct packed {
        logic valid;
        logic post;
        logic [3:0] frame_fmt;
        logic [7:0] vector;
    } take_t;

endpackage

// ===== rtl/_unused_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== bench/test_fp_exception_detect_priority.sv
`timescale 1ns/10ps
`default_nettype none

module test_fp_exception_detect_priority;
    import fp_exc_pkg::*;

    typedef struct packed {
        take_t t;
        logic [15:0] sr;
    } note_t;

    localparam int LIMIT = 20000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    insn_t insn = '0;
    result_t result = '0;
    logic [15:0] sr_in = '0, sr_saved, sr_out;
    take_t take;
    note_t q[$];
    note_t nt;
    int errors = 0, checks_done = 0, cycles = 0;
    integer seed = 32'h559c;

    always #12.5 aclk = ~aclk;

    fp_exception_detect_priority dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .insn(insn), .result(result), .sr_in(sr_in),
        .take(take), .sr_saved(sr_saved), .sr_out(sr_out), .irq(irq)
    );

    // ************************************************************
    // Checking
    // ************************************************************
    task automatic chk(input logic [79:0] g, input logic [79:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic test_done;
        if (q.size() != 0) errors++;
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // An unexpected trap shows as a take pulse with no note queued.
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && take.valid === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
                $display("[FAIL] t=%0t got %h exp %h", $time, take, 14'h0);
            end else begin
                nt = q.pop_front();
                chk(take, nt.t);
                chk(sr_saved, nt.sr);
                chk(sr_out, (nt.sr | 16'h2000) & 16'h3FFF);
            end
        end
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            test_done();
        end
    end

    // ************************************************************
    // Bus and event drivers
    // ************************************************************
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e,
                      input logic [31:0] em, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rresp, er);
        if (em != 0) chk(rdata & em, e & em);
    endtask

    task automatic slot(input logic [5:0] b, input logic [79:0] e);
        rd(b, e[31:0], 32'hFFFF_FFFF, RESP_OKAY);
        rd(b + 6'h04, e[63:32], 32'hFFFF_FFFF, RESP_OKAY);
        rd(b + 6'h08, {16'h0, e[79:64]}, 32'hFFFF_FFFF, RESP_OKAY);
    endtask

    task automatic fire(input result_t r, input insn_t i,
                        input logic [15:0] s, input logic ex, input take_t t);
        note_t n;
        @(posedge aclk);
        result <= r;
        insn <= i;
        sr_in <= s;
        n.t = t;
        n.sr = s;
        if (ex) q.push_back(n);
        @(posedge aclk);
        result.valid <= 1'b0;
        insn.valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    function automatic take_t arith(input logic [7:0] trig);
        take_t t;
        t = '0;
        for (int b = 0; b < 8; b++) begin
            if (trig[b]) begin
                t.valid = 1'b1;
                case (b)
                    B_UNORD: t.vector = VEC_UNORD;
                    B_SIGNALING_NAN_EXC: t.vector = VEC_SIGNALING_NAN_EXC;
                    B_OPERAND_ERROR_EXC: t.vector = VEC_OPERAND_ERROR_EXC;
                    B_OVERFLOW_EXC: t.vector = VEC_OVERFLOW_EXC;
                    B_UNDERFLOW_EXC: t.vector = VEC_UNDERFLOW_EXC;
                    B_DZ: t.vector = VEC_DZ;
                    default: t.vector = VEC_INEX;
                endcase
            end
        end
        return t;
    endfunction

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        result_t r;
        insn_t i;
        take_t t;
        logic [7:0] en, ex, nm;
        logic [95:0] ps;
        logic [2:0] oc;
        logic dn;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_FP_STATUS, RST_WORD, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_FP_CONTROL, RST_WORD, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_INT_MASK, RST_WORD, 32'hFFFF_FFFF, RESP_OKAY);
        rd(6'h28, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(6'h01, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(OFS_DST_SLOT0, $random(seed), RESP_SLVERR);
        wr(6'h3C, $random(seed), RESP_SLVERR);
        r = '0;
        r.valid = 1'b1;
        r.nonmask = 8'h10;
        wr(OFS_INT_MASK, 32'h1, RESP_OKAY);
        fire(r, '0, 16'hC000, 1'b1, arith(8'h10));
        chk(irq, 1'b1);
        rd(OFS_INT_STATUS, 32'h1, 32'h3, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(OFS_INT_MASK, 32'h0, RESP_OKAY);
        fire(r, '0, 16'h4000, 1'b1, arith(8'h10));
        chk(irq, 1'b0);
        // Recorded or software-set status must never trap on its own.
        wr(OFS_FP_CONTROL, 32'h0, RESP_OKAY);
        wr(OFS_FP_STATUS, 32'h0, RESP_OKAY);
        r = '0;
        r.valid = 1'b1;
        r.exc = 8'h10;
        fire(r, '0, 16'h0, 1'b0, '0);
        wr(OFS_FP_CONTROL, 32'h0000_FF00, RESP_OKAY);
        wr(OFS_FP_STATUS, 32'h0000_FE00, RESP_OKAY);
        repeat (3) @(posedge aclk);
        wr(OFS_FP_STATUS, 32'h0000_0100, RESP_OKAY);
        rd(OFS_FP_STATUS, 32'h0100, 32'hFF00, RESP_OKAY);
        for (int k = 0; k < 24; k++) begin
            en = $random(seed);
            ex = $random(seed);
            nm = k[0] ? 8'h0 : 8'($random(seed));
            dn = (k % 4 == 2);
            wr(OFS_FP_CONTROL, {16'h0, en, 8'h0}, RESP_OKAY);
            wr(OFS_FP_STATUS, 32'h0, RESP_OKAY);
            r.exc = ex;
            r.nonmask = nm;
            r.result_denorm = dn;
            t = arith((ex & en & HW_BITS) | (nm & NONMASK_BITS)
                      | {4'h0, dn, 3'h0});
            fire(r, '0, 16'($random(seed)), t.valid, t);
            if (nm == 0 && !dn)
                rd(OFS_FP_STATUS, {16'h0, ex & HW_BITS, 8'h0}, 32'hFF00,
                   RESP_OKAY);
        end
        for (int k = 0; k < 24; k++) begin
            oc = (k < 6) ? OPC_REG_REG : (k < 12) ? OPC_MEM_REG :
                 (k < 18) ? OPC_REG_MEM : 3'h1;
            ps = {$random(seed), $random(seed), $random(seed)};
            i = '0;
            i.valid = 1'b1;
            i.opclass = oc;
            i.src_op = 80'({$random(seed), $random(seed), $random(seed)});
            i.dst_op = 80'({$random(seed), $random(seed), $random(seed)});
            i.packed_src = ps;
            {i.src_denorm, i.src_unnorm, i.dst_denorm, i.dst_unnorm,
             i.src_packed, i.dst_packed} = 6'h20 >> (k % 6);
            t.valid = 1'b1;
            t.post = (oc == OPC_REG_MEM);
            t.frame_fmt = t.post ? FMT_POST : FMT_PRE;
            t.vector = VEC_UNSUP;
            fire('0, i, 16'($random(seed)), oc != 3'h1, t);
            if (oc != 3'h1) begin
                if (k % 6 < 2) slot(OFS_EXC_SLOT0, i.src_op);
                if (k % 6 == 2 || k % 6 == 3)
                    slot(OFS_DST_SLOT0, i.dst_op);
                if (k % 6 == 4) begin
                    slot(OFS_EXC_SLOT0, {16'h0, ps[63:0]});
                    slot(OFS_DST_SLOT0, {48'h0, ps[95:64]});
                end
            end
        end
        // Both taken and unsupported causes are pending by now.
        wr(OFS_INT_MASK, 32'h2, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        rd(OFS_INT_STATUS, 32'h3, 32'h3, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(irq, 1'b0);
        test_done();
    end
endmodule

`default_nettype wire
